// [ppmux_top.sv]
// Per-pin port and peripheral function multiplexer for a 4-bit and an 8-bit port group.
//
// Notes on behaviour
// - Four-bit group carries port or 16-bit timer.
// - Port or control mode chosen per pin.
// - Group A direction bit sets pin direction.
// - Group A pull-up follows its option register while the pin is an input.
// - Eight-bit group carries irq, serial, timers.
// - Group B direction bit sets pin direction.
// - Group B pull-up follows its option register while the pin is an input.
// - Interrupt five edge: rising, falling, both.
// - First timer pin: count clock and captures.
// - Second timer pin: capture A, shares output.
// - Every pin is an input after reset.
// - Serial clock pin is bidirectional, shares transmit.
// - Receive inputs share pins as listed.
// - Timer 8 input and output share pin.
module ppmux_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ppmux_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ppmux_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [ppmux_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    input wire logic [ppmux_pkg::PORT_A_W-1:0] pin_a_in,
    output logic [ppmux_pkg::PORT_A_W-1:0] pin_a_out,
    output logic [ppmux_pkg::PORT_A_W-1:0] pin_a_oe,
    output logic [ppmux_pkg::PORT_A_W-1:0] pin_a_pullup,
    input wire logic [ppmux_pkg::PORT_B_W-1:0] pin_b_in,
    output logic [ppmux_pkg::PORT_B_W-1:0] pin_b_out,
    output logic [ppmux_pkg::PORT_B_W-1:0] pin_b_oe,
    output logic [ppmux_pkg::PORT_B_W-1:0] pin_b_pullup,
    input wire logic timer16_out,
    input wire logic csi_data_out,
    input wire logic csi_clock_out,
    input wire logic uart_a_tx,
    input wire logic uart_b_tx,
    input wire logic timer8_out,
    input wire logic timer_h_a_out,
    input wire logic timer_h_b_out,
    output logic timer16_count_capture_in,
    output logic timer16_capture_in,
    output logic csi_data_in,
    output logic csi_clock_in,
    output logic uart_a_rx,
    output logic uart_b_rx,
    output logic timer8_count_in,
    output logic ext_irq_in_5,
    output logic ext_irq_5_event
);
    localparam int AW = ppmux_pkg::PORT_A_W;
    localparam int BW = ppmux_pkg::PORT_B_W;

    // Edge qualifier, used for the event flag and for the peripheral pulse.
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        edge_hit = (sel[ppmux_pkg::EDGE_RISE_BIT] & rise) | (sel[ppmux_pkg::EDGE_FALL_BIT] & fall);
    endfunction

    // Software-visible state.
    logic [AW-1:0] port_a_out_reg;
    logic [AW-1:0] port_a_direction_reg;
    logic [AW-1:0] port_a_pullup_reg;
    logic [AW-1:0] port_a_mode_reg;
    logic [BW-1:0] port_b_out_reg;
    logic [BW-1:0] port_b_direction_reg;
    logic [BW-1:0] port_b_pullup_reg;
    logic [BW-1:0] port_b_mode_reg;
    logic [0:0] alt_sel_reg;
    logic [1:0] irq_edge_reg;
    logic [0:0] irq_status_reg;
    logic [0:0] irq_mask_reg;
    logic [0:0] irq_status_next;

    // Synchronised pad levels and their edges.
    // Pads are asynchronous to the system clock, so no logic reads them before two flip-flops.
    ppmux_sync_if sif ();

    ppmux_sync u_sync (
        .clock(clock),
        .rst(rst),
        .sif(sif)
    );

    assign sif.raw = {pin_b_in, pin_a_in};

    logic [AW-1:0] lvl_a;
    logic [BW-1:0] lvl_b;
    assign lvl_a = sif.level[AW-1:0];
    assign lvl_b = sif.level[ppmux_pkg::PIN_W-1:AW];

    // Address decode.
    logic hit_a_out;
    logic hit_a_dir;
    logic hit_a_pu;
    logic hit_a_mode;
    logic hit_a_pin;
    logic hit_b_out;
    logic hit_b_dir;
    logic hit_b_pu;
    logic hit_b_mode;
    logic hit_b_pin;
    logic hit_alt;
    logic hit_edge;
    logic hit_status;
    logic hit_mask;
    assign hit_a_out = reg_addr == ppmux_pkg::OFF_A_OUT;
    assign hit_a_dir = reg_addr == ppmux_pkg::OFF_A_DIR;
    assign hit_a_pu = reg_addr == ppmux_pkg::OFF_A_PULLUP;
    assign hit_a_mode = reg_addr == ppmux_pkg::OFF_A_MODE;
    assign hit_a_pin = reg_addr == ppmux_pkg::OFF_A_PIN;
    assign hit_b_out = reg_addr == ppmux_pkg::OFF_B_OUT;
    assign hit_b_dir = reg_addr == ppmux_pkg::OFF_B_DIR;
    assign hit_b_pu = reg_addr == ppmux_pkg::OFF_B_PULLUP;
    assign hit_b_mode = reg_addr == ppmux_pkg::OFF_B_MODE;
    assign hit_b_pin = reg_addr == ppmux_pkg::OFF_B_PIN;
    assign hit_alt = reg_addr == ppmux_pkg::OFF_ALT_SEL;
    assign hit_edge = reg_addr == ppmux_pkg::OFF_IRQ_EDGE;
    assign hit_status = reg_addr == ppmux_pkg::OFF_IRQ_STATUS;
    assign hit_mask = reg_addr == ppmux_pkg::OFF_IRQ_MASK;

    // Read selection; unmapped offsets read as zero.
    // Pin levels are read after the synchroniser, so software sees a pad two cycles late.
    localparam int DATA_W_LOCAL = ppmux_pkg::DATA_W;
    logic [DATA_W_LOCAL-1:0] rd_mux;
    assign rd_mux = ({8{hit_a_out}} & {4'h0, port_a_out_reg})
        | ({8{hit_a_dir}} & {4'h0, port_a_direction_reg})
        | ({8{hit_a_pu}} & {4'h0, port_a_pullup_reg})
        | ({8{hit_a_mode}} & {4'h0, port_a_mode_reg})
        | ({8{hit_a_pin}} & {4'h0, lvl_a})
        | ({8{hit_b_out}} & port_b_out_reg)
        | ({8{hit_b_dir}} & port_b_direction_reg)
        | ({8{hit_b_pu}} & port_b_pullup_reg)
        | ({8{hit_b_mode}} & port_b_mode_reg)
        | ({8{hit_b_pin}} & lvl_b)
        | ({8{hit_alt}} & {7'h00, alt_sel_reg})
        | ({8{hit_edge}} & {6'h00, irq_edge_reg})
        | ({8{hit_status}} & {7'h00, irq_status_reg})
        | ({8{hit_mask}} & {7'h00, irq_mask_reg});

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_read ? rd_mux : '0;
        end
    end

    // reset to input
    // Direction registers reset to all inputs and modes to port mode.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_a_out_reg <= ppmux_pkg::RST_A_OUT;
            port_a_direction_reg <= ppmux_pkg::RST_A_DIR;
            port_a_pullup_reg <= ppmux_pkg::RST_A_PULLUP;
            port_a_mode_reg <= ppmux_pkg::RST_A_MODE;
        end else if (reg_write) begin
            if (hit_a_out) port_a_out_reg <= reg_wdata[AW-1:0];
            if (hit_a_dir) port_a_direction_reg <= reg_wdata[AW-1:0];
            if (hit_a_pu) port_a_pullup_reg <= reg_wdata[AW-1:0];
            if (hit_a_mode) port_a_mode_reg <= reg_wdata[AW-1:0];
        end
    end

    // Group B and the shared configuration registers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_b_out_reg <= ppmux_pkg::RST_B_OUT;
            port_b_direction_reg <= ppmux_pkg::RST_B_DIR;
            port_b_pullup_reg <= ppmux_pkg::RST_B_PULLUP;
            port_b_mode_reg <= ppmux_pkg::RST_B_MODE;
            alt_sel_reg <= ppmux_pkg::RST_ALT_SEL;
            irq_edge_reg <= ppmux_pkg::RST_IRQ_EDGE;
            irq_mask_reg <= ppmux_pkg::RST_IRQ_MASK;
        end else if (reg_write) begin
            if (hit_b_out) port_b_out_reg <= reg_wdata;
            if (hit_b_dir) port_b_direction_reg <= reg_wdata;
            if (hit_b_pu) port_b_pullup_reg <= reg_wdata;
            if (hit_b_mode) port_b_mode_reg <= reg_wdata;
            if (hit_alt) alt_sel_reg <= reg_wdata[0:0];
            if (hit_edge) irq_edge_reg <= reg_wdata[1:0];
            if (hit_mask) irq_mask_reg <= reg_wdata[0:0];
        end
    end

    // Peripheral output candidates per pin; pins without an output function use the latch.
    logic [AW-1:0] func_a;
    logic [BW-1:0] func_b;
    logic p10_func;
    assign p10_func = alt_sel_reg[ppmux_pkg::ALT_UART_A_TX_BIT] ? uart_a_tx : csi_clock_out;
    assign func_a = {port_a_out_reg[3], port_a_out_reg[2], timer16_out, port_a_out_reg[0]};
    assign func_b = {timer8_out, timer_h_b_out, timer_h_a_out, port_b_out_reg[4],
        uart_b_tx, csi_data_out, port_b_out_reg[1], p10_func};

    // Drive enable follows the direction bit in both modes; control mode picks the function.
    logic [AW-1:0] oe_a_next;
    logic [AW-1:0] val_a_next;
    logic [AW-1:0] pu_a_next;
    logic [BW-1:0] oe_b_next;
    logic [BW-1:0] val_b_next;
    logic [BW-1:0] pu_b_next;
    genvar gi;
    generate
        for (gi = 0; gi < AW; gi++) begin : g_pin_a
            assign oe_a_next[gi] = ~port_a_direction_reg[gi];
            assign val_a_next[gi] = port_a_mode_reg[gi] ? func_a[gi] : port_a_out_reg[gi];
            assign pu_a_next[gi] = port_a_pullup_reg[gi] & port_a_direction_reg[gi];
        end
        for (gi = 0; gi < BW; gi++) begin : g_pin_b
            assign oe_b_next[gi] = ~port_b_direction_reg[gi];
            assign val_b_next[gi] = port_b_mode_reg[gi] ? func_b[gi] : port_b_out_reg[gi];
            assign pu_b_next[gi] = port_b_pullup_reg[gi] & port_b_direction_reg[gi];
        end
    endgenerate

    // Pad controls are registered so the pads never see decode glitches.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_a_out <= '0;
            pin_a_oe <= '0;
            pin_a_pullup <= '0;
            pin_b_out <= '0;
            pin_b_oe <= '0;
            pin_b_pullup <= '0;
        end else begin
            pin_a_out <= val_a_next;
            pin_a_oe <= oe_a_next;
            pin_a_pullup <= pu_a_next;
            pin_b_out <= val_b_next;
            pin_b_oe <= oe_b_next;
            pin_b_pullup <= pu_b_next;
        end
    end

    // A peripheral sees its pin only while that pin is in control mode as an input.
    // The gate keeps a driving pin from echoing its own output back into a peripheral.
    logic [AW-1:0] take_a;
    logic [BW-1:0] take_b;
    assign take_a = port_a_mode_reg & port_a_direction_reg;
    assign take_b = port_b_mode_reg & port_b_direction_reg;

    logic irq5_edge;
    assign irq5_edge = take_b[ppmux_pkg::PB_TIMER_H_B]
        & edge_hit(irq_edge_reg, sif.rise[AW + ppmux_pkg::PB_TIMER_H_B],
        sif.fall[AW + ppmux_pkg::PB_TIMER_H_B]);

    // Peripheral inputs; receive lines idle high when not connected, others idle low.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer16_count_capture_in <= 1'b0;
            timer16_capture_in <= 1'b0;
            csi_data_in <= 1'b0;
            csi_clock_in <= 1'b0;
            uart_a_rx <= 1'b1;
            uart_b_rx <= 1'b1;
            timer8_count_in <= 1'b0;
            ext_irq_in_5 <= 1'b0;
            ext_irq_5_event <= 1'b0;
        end else begin
            timer16_count_capture_in <= take_a[ppmux_pkg::PA_TIMER16_COUNT]
                & lvl_a[ppmux_pkg::PA_TIMER16_COUNT];
            timer16_capture_in <= take_a[ppmux_pkg::PA_TIMER16_SHARED]
                & lvl_a[ppmux_pkg::PA_TIMER16_SHARED];
            csi_data_in <= take_b[ppmux_pkg::PB_CSI_DATA_IN] & lvl_b[ppmux_pkg::PB_CSI_DATA_IN];
            uart_a_rx <= ~take_b[ppmux_pkg::PB_CSI_DATA_IN] | lvl_b[ppmux_pkg::PB_CSI_DATA_IN];
            uart_b_rx <= ~take_b[ppmux_pkg::PB_UART_B_RX] | lvl_b[ppmux_pkg::PB_UART_B_RX];
            csi_clock_in <= take_b[ppmux_pkg::PB_CSI_CLOCK] & lvl_b[ppmux_pkg::PB_CSI_CLOCK];
            timer8_count_in <= take_b[ppmux_pkg::PB_TIMER8] & lvl_b[ppmux_pkg::PB_TIMER8];
            ext_irq_in_5 <= take_b[ppmux_pkg::PB_TIMER_H_B] & lvl_b[ppmux_pkg::PB_TIMER_H_B];
            ext_irq_5_event <= irq5_edge;
        end
    end

    // Read of the status register clears it, but a new edge in that cycle wins.
    // Losing an edge is worse than one extra interrupt, hence the set has priority.
    assign irq_status_next[ppmux_pkg::STAT_EXT_IRQ_5_BIT] = irq5_edge
        | (irq_status_reg[ppmux_pkg::STAT_EXT_IRQ_5_BIT] & ~(reg_read & hit_status));

    // Sticky status and the masked level interrupt.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_status_reg <= ppmux_pkg::RST_IRQ_STATUS;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq <= |(irq_status_next & irq_mask_reg);
        end
    end
endmodule

// [ppmux_pkg.sv]
// Package with register map, field layout, reset values and widths of the pin function mux.
package ppmux_pkg;

    // Bus and port widths.
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int PORT_A_W = 4;
    localparam int PORT_B_W = 8;
    localparam int PIN_W = 12;

    // Byte offsets of the registers on the plain register port.
    localparam logic [5:0] OFF_A_OUT = 6'h00;
    localparam logic [5:0] OFF_A_DIR = 6'h04;
    localparam logic [5:0] OFF_A_PULLUP = 6'h08;
    localparam logic [5:0] OFF_A_MODE = 6'h0c;
    localparam logic [5:0] OFF_A_PIN = 6'h10;
    localparam logic [5:0] OFF_B_OUT = 6'h14;
    localparam logic [5:0] OFF_B_DIR = 6'h18;
    localparam logic [5:0] OFF_B_PULLUP = 6'h1c;
    localparam logic [5:0] OFF_B_MODE = 6'h20;
    localparam logic [5:0] OFF_B_PIN = 6'h24;
    localparam logic [5:0] OFF_ALT_SEL = 6'h28;
    localparam logic [5:0] OFF_IRQ_EDGE = 6'h2c;
    localparam logic [5:0] OFF_IRQ_STATUS = 6'h30;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h34;

    // Reset values: port mode, every pin an input, no pull-up.
    localparam logic [3:0] RST_A_OUT = 4'h0;
    localparam logic [3:0] RST_A_DIR = 4'hf;
    localparam logic [3:0] RST_A_PULLUP = 4'h0;
    localparam logic [3:0] RST_A_MODE = 4'h0;
    localparam logic [7:0] RST_B_OUT = 8'h00;
    localparam logic [7:0] RST_B_DIR = 8'hff;
    localparam logic [7:0] RST_B_PULLUP = 8'h00;
    localparam logic [7:0] RST_B_MODE = 8'h00;
    localparam logic [0:0] RST_ALT_SEL = 1'h0;
    localparam logic [1:0] RST_IRQ_EDGE = 2'h0;
    localparam logic [0:0] RST_IRQ_STATUS = 1'h0;
    localparam logic [0:0] RST_IRQ_MASK = 1'h0;

    // Field positions.
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;
    localparam int ALT_UART_A_TX_BIT = 0;
    localparam int STAT_EXT_IRQ_5_BIT = 0;

    // Pin positions inside the two groups.
    localparam int PA_TIMER16_COUNT = 0;
    localparam int PA_TIMER16_SHARED = 1;
    localparam int PB_CSI_CLOCK = 0;
    localparam int PB_CSI_DATA_IN = 1;
    localparam int PB_CSI_DATA_OUT = 2;
    localparam int PB_UART_B_TX = 3;
    localparam int PB_UART_B_RX = 4;
    localparam int PB_TIMER_H_A = 5;
    localparam int PB_TIMER_H_B = 6;
    localparam int PB_TIMER8 = 7;

endpackage

// [ppmux_sync_if.sv]
// Interface between the mux and its pin synchroniser.
interface ppmux_sync_if;
    logic [ppmux_pkg::PIN_W-1:0] raw;
    logic [ppmux_pkg::PIN_W-1:0] level;
    logic [ppmux_pkg::PIN_W-1:0] rise;
    logic [ppmux_pkg::PIN_W-1:0] fall;
    modport sync_side (input raw, output level, output rise, output fall);
    modport mux_side (output raw, input level, input rise, input fall);
endinterface

// [ppmux_sync.sv]
// Two-flop synchroniser and edge detector for all twelve pads.
module ppmux_sync (
    input wire logic clock,
    input wire logic rst,
    ppmux_sync_if.sync_side sif
);
    logic [ppmux_pkg::PIN_W-1:0] meta_reg;
    logic [ppmux_pkg::PIN_W-1:0] sync_reg;
    logic [ppmux_pkg::PIN_W-1:0] prev_reg;

    // The first stage is read only by the second; edges are taken between later stages.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= sif.raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edge pulses last one cycle each.
    assign sif.level = sync_reg;
    assign sif.rise = sync_reg & ~prev_reg;
    assign sif.fall = ~sync_reg & prev_reg;
endmodule

// [ppmux_checker.sv]
// Concurrent checks on the ports of the pin function mux.
module ppmux_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic irq,
    input wire logic [3:0] pin_a_oe,
    input wire logic [3:0] pin_a_pullup,
    input wire logic [7:0] pin_b_oe,
    input wire logic [7:0] pin_b_pullup,
    input wire logic ext_irq_5_event
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Read data is zero except in the cycle after a read strobe.
    chk_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    // A driving pad never keeps its pull-up connected.
    chk_a_pull_drive: assert property ((pin_a_oe & pin_a_pullup) == 4'h0)
        else $error("group a pull-up on a driven pad");
    chk_b_pull_drive: assert property ((pin_b_oe & pin_b_pullup) == 8'h00)
        else $error("group b pull-up on a driven pad");
    // Pad direction and pull-up move only two cycles after a register write.
    chk_a_dir_write: assert property ($changed(pin_a_oe) |-> $past(reg_write, 2))
        else $error("group a drive changed without a write");
    chk_b_dir_write: assert property ($changed(pin_b_oe) |-> $past(reg_write, 2))
        else $error("group b drive changed without a write");
    chk_a_pull_write: assert property ($changed(pin_a_pullup) |-> $past(reg_write, 2))
        else $error("group a pull-up changed without a write");
    chk_b_pull_write: assert property ($changed(pin_b_pullup) |-> $past(reg_write, 2))
        else $error("group b pull-up changed without a write");
    // The first cycle after reset leaves every pad an input.
    chk_reset_inputs: assert property ($past(rst) |-> pin_a_oe == 4'h0 && pin_b_oe == 8'h00)
        else $error("pad driving right after reset");
    // The interrupt rises only from an edge event or a mask write.
    chk_irq_cause: assert property ($rose(irq) |-> ext_irq_5_event || $past(ext_irq_5_event)
        || $past(reg_write) || $past(reg_write, 2) || $past(reg_write, 3))
        else $error("interrupt rose without cause");
    chk_irq_clear: assert property ($fell(irq) |-> $past(reg_read) || $past(reg_read, 2)
        || $past(reg_read, 3) || $past(reg_write, 2) || $past(reg_write, 3))
        else $error("interrupt fell without read or write");
endmodule

// [ppmux_board_model.sv]
// Board model: external drivers, pull-ups and floating pads around the mux.
module ppmux_board_model (
    input wire logic clock,
    input wire logic [11:0] pad_out,
    input wire logic [11:0] pad_oe,
    input wire logic [11:0] pad_pullup,
    input wire logic [11:0] ext_drv,
    input wire logic [11:0] ext_en,
    output logic [11:0] pad_in
);
    logic [11:0] flt_reg = 12'h5a5;
    // An undriven pad without pull-up wanders, so nothing may trust its level.
    always_ff @(posedge clock) begin
        flt_reg <= ~flt_reg;
    end
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_drv)
        | (~pad_oe & ~ext_en & pad_pullup) | (~pad_oe & ~ext_en & ~pad_pullup & flt_reg);
endmodule

// [tb.sv]
// Self-checking bench for the pin function mux with its board model.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic rd_seen = 1'b0;
    logic irq;
    logic [7:0] reg_rdata;
    logic [3:0] pin_a_in, pin_a_out, pin_a_oe, pin_a_pullup;
    logic [7:0] pin_b_in, pin_b_out, pin_b_oe, pin_b_pullup;
    logic [7:0] per_out = 8'h00;
    logic [8:0] per_in;
    logic [11:0] ext_drv = 12'h000;
    logic [11:0] ext_en = 12'hfff;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    localparam logic [5:0] offs_tab [12] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h14, 6'h18,
        6'h1c, 6'h20, 6'h28, 6'h2c, 6'h34, 6'h3c};
    localparam logic [7:0] rst_tab [12] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] msk_tab [12] = '{8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h01, 8'h03, 8'h01, 8'h00};

    ppmux_top dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
        .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_a_pullup(pin_a_pullup), .pin_b_in(pin_b_in), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .pin_b_pullup(pin_b_pullup), .timer16_out(per_out[0]),
        .csi_data_out(per_out[1]), .csi_clock_out(per_out[2]), .uart_a_tx(per_out[3]),
        .uart_b_tx(per_out[4]), .timer8_out(per_out[5]), .timer_h_a_out(per_out[6]),
        .timer_h_b_out(per_out[7]), .timer16_count_capture_in(per_in[0]),
        .timer16_capture_in(per_in[1]), .csi_data_in(per_in[2]), .csi_clock_in(per_in[3]),
        .uart_a_rx(per_in[4]), .uart_b_rx(per_in[5]), .timer8_count_in(per_in[6]),
        .ext_irq_in_5(per_in[7]), .ext_irq_5_event(per_in[8]));
    ppmux_board_model board_u (.clock(clock), .pad_out({pin_b_out, pin_a_out}),
        .pad_oe({pin_b_oe, pin_a_oe}), .pad_pullup({pin_b_pullup, pin_a_pullup}),
        .ext_drv(ext_drv), .ext_en(ext_en), .pad_in({pin_b_in, pin_a_in}));

    // Free-running system clock.
    initial begin
        forever #4 clock = ~clock;
    end

    task automatic end_sim();
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Strobes drop after one cycle and an idle edge follows, so no signal is set twice at once.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask

    function automatic logic [11:0] grp(input logic [11:0] v, input bit g);
        return g ? {4'h0, v[11:4]} : {8'h00, v[3:0]};
    endfunction

    // Port mode of one group: drive, pull-up and read back of pad levels.
    task automatic port_grp(input logic [5:0] b, input logic [7:0] w, input bit g);
        logic [7:0] v, p, d;
        logic [11:0] x;
        v = 8'($urandom) & w;
        p = 8'($urandom) & w;
        d = 8'($urandom) & w;
        ext_drv <= 12'($urandom);
        wr(b + 6'h0c, 8'h00);
        wr(b, v);
        wr(b + 6'h08, p);
        wr(b + 6'h04, 8'h00);
        cyc(3);
        chk("pad_oe", {4'h0, w}, grp({pin_b_oe, pin_a_oe}, g));
        chk("pad_out", {4'h0, v}, grp({pin_b_out, pin_a_out}, g));
        chk("pad_pullup", 12'h000, grp({pin_b_pullup, pin_a_pullup}, g));
        wr(b + 6'h04, d);
        cyc(4);
        x = grp(ext_drv, g);
        chk("pad_oe", {4'h0, w & ~d}, grp({pin_b_oe, pin_a_oe}, g));
        chk("pad_pullup", {4'h0, p & d}, grp({pin_b_pullup, pin_a_pullup}, g));
        rd(b + 6'h10, (v & ~d) | (x[7:0] & d));
    endtask

    // Read data stands one cycle after the strobe; the oldest note is matched there.
    always @(posedge clock) begin
        rd_seen <= reg_read;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    always @(negedge clock) begin
        if (rd_seen) begin
            chk("reg_rdata", {4'h0, exp_q.pop_front()}, {4'h0, reg_rdata});
        end
    end

    // Main sequence: reset, port mode, peripheral routing, interrupt, register access.
    initial begin
        logic [7:0] v, p, d;
        logic hit;
        void'($urandom(32'hd928ac45));
        cyc(3);
        rst <= 1'b0;
        @(posedge clock);
        chk("pad_oe", 12'h000, {pin_b_oe, pin_a_oe});
        chk("per_in", 12'h030, {3'h0, per_in});
        rd(6'h30, 8'h00);
        for (int i = 0; i < 12; i++) rd(offs_tab[i], rst_tab[i]);
        port_grp(6'h00, 8'h0f, 1'b0);
        port_grp(6'h14, 8'hff, 1'b1);
        for (int m = 0; m < 2; m++) begin
            wr(6'h04, 8'h0f);
            wr(6'h18, 8'hff);
            wr(6'h0c, m ? 8'h0f : 8'h00);
            wr(6'h20, m ? 8'hff : 8'h00);
            ext_drv <= 12'($urandom);
            cyc(5);
            chk("per_in", m ? {4'h0, ext_drv[10], ext_drv[11], ext_drv[8], ext_drv[5],
                ext_drv[4], ext_drv[5], ext_drv[1], ext_drv[0]} : 12'h030, {3'h0, per_in});
        end
        v = 8'($urandom);
        p = 8'($urandom);
        d = 8'($urandom);
        per_out <= d;
        wr(6'h00, v);
        wr(6'h14, p);
        wr(6'h04, 8'h00);
        wr(6'h18, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr(6'h28, 8'(s));
            cyc(3);
            chk("pad_out", {d[5], d[7], d[6], p[4], d[4], d[1], p[1], s ? d[3] : d[2],
                v[3], v[2], d[0], v[0]}, {pin_b_out, pin_a_out});
        end
        wr(6'h18, 8'hff);
        wr(6'h20, 8'h40);
        ext_drv[10] <= 1'b0;
        cyc(5);
        for (int e = 0; e < 4; e++) begin
            wr(6'h2c, 8'(e));
            wr(6'h34, {7'h00, e != 2});
            for (int lv = 1; lv >= 0; lv--) begin
                ext_drv[10] <= lv[0];
                cyc(5);
                hit = lv ? e[0] : e[1];
                chk("irq", {11'h000, hit & (e != 2)}, {11'h000, irq});
                rd(6'h30, {7'h00, hit});
                cyc(1);
                chk("irq", 12'h000, {11'h000, irq});
            end
        end
        for (int i = 0; i < 12; i++) begin
            v = 8'($urandom);
            wr(offs_tab[i], v);
            rd(offs_tab[i], v & msk_tab[i]);
        end
        cyc(4);
        end_sim();
    end
endmodule

bind ppmux_top ppmux_checker chk_u (.clock(clock), .rst(rst), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .pin_a_oe(pin_a_oe),
    .pin_a_pullup(pin_a_pullup), .pin_b_oe(pin_b_oe), .pin_b_pullup(pin_b_pullup),
    .ext_irq_5_event(ext_irq_5_event));
